// ==== inc/cidwc_pkg.sv ====
package cidwc_pkg;

	// ----------------------------------------------------------------
	// Register map, byte addresses on the register bus.
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL    = 8'h00; // monitor_control_reg.
	localparam logic [7:0] ADDR_ENABLE_SET = 8'h04; // counter_enable_set_reg.
	localparam logic [7:0] ADDR_ENABLE_CLR = 8'h08; // Enable clear.
	localparam logic [7:0] ADDR_SELECT     = 8'h0C; // counter_select_reg.
	localparam logic [7:0] ADDR_EVENT_TYPE = 8'h10; // event_type_reg.
	localparam logic [7:0] ADDR_COUNT      = 8'h14; // Selected count.
	localparam logic [7:0] ADDR_ENABLE_RD  = 8'h18; // Enable status.

	// ----------------------------------------------------------------
	// Field positions, codes and reset values.
	// ----------------------------------------------------------------
	localparam int         CTRL_ENABLE_BIT = 0;     // Global enable.
	localparam int         CID_EVENT_BIT   = 12;    // Output bus bit.
	localparam logic [7:0] CODE_CID_WRITE  = 8'h0B; // Context ID write.
	localparam logic [7:0] CODE_RESET      = 8'h00; // Type after reset.
	localparam logic [1:0] RESP_OKAY       = 2'b00;
	localparam logic [1:0] RESP_SLVERR     = 2'b10;

	// Context identifier access strobes from the core.
	typedef struct packed {
		logic write_exec; // Executed write of context_id_reg.
		logic read_exec;  // Executed read of context_id_reg.
	} cidwc_access_s;

endpackage

// ==== rtl/cidwc_counter.sv ====
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cidwc_counter
	import cidwc_pkg::*;
#(
	parameter int NUM_CNT = 8,
	parameter int CNT_W   = 32,
	parameter int EVT_W   = 16
) (
	input  wire logic                 ref_clk_in,
	input  wire logic                 rst_n_in,
	input  wire cidwc_access_s        cid_access_in,
	input  wire logic [7:0]           s_axi_awaddr_in,
	input  wire logic                 s_axi_awvalid_in,
	output logic                      s_axi_awready_out,
	input  wire logic [31:0]          s_axi_wdata_in,
	input  wire logic [3:0]           s_axi_wstrb_in,
	input  wire logic                 s_axi_wvalid_in,
	output logic                      s_axi_wready_out,
	output logic [1:0]                s_axi_bresp_out,
	output logic                      s_axi_bvalid_out,
	input  wire logic                 s_axi_bready_in,
	input  wire logic [7:0]           s_axi_araddr_in,
	input  wire logic                 s_axi_arvalid_in,
	output logic                      s_axi_arready_out,
	output logic [31:0]               s_axi_rdata_out,
	output logic [1:0]                s_axi_rresp_out,
	output logic                      s_axi_rvalid_out,
	input  wire logic                 s_axi_rready_in,
	output logic [EVT_W-1:0]          event_output_bus_out
);

	// ----------------------------------------------------------------
	// Configuration state.
	// ----------------------------------------------------------------
	logic                    global_enable;       // monitor_control_reg E.
	logic [NUM_CNT-1:0]      counter_enable_bit;  // Per-counter enable.
	logic [2:0]              counter_select;      // Selected counter.
	logic [7:0]              event_code_field [NUM_CNT]; // Mapped codes.
	logic [CNT_W-1:0]        count [NUM_CNT];     // Event counters.

	// Write channel holding state; address and data may arrive apart.
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	logic [31:0] wr_bits; // Write data masked to its strobed byte lanes.

	// A write commits once both halves are held and no response waits.
	assign do_write = aw_held && w_held && !s_axi_bvalid_out;

	// Merges byte lanes of a write into an old word.
	function automatic logic [31:0] merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// The masked word is held in a net because a function result cannot
	// be part-selected directly.
	assign wr_bits = merge(32'h0000_0000, w_data, w_strb);

	// ----------------------------------------------------------------
	// Write address and data capture.
	// ----------------------------------------------------------------
	// Each half is accepted independently and held until the commit.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out  <= 1'b0;
		end else begin
			// Ready is raised only while the holding slot is empty.
			s_axi_awready_out <= !aw_held && !s_axi_awready_out;
			s_axi_wready_out  <= !w_held && !s_axi_wready_out;
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata_in;
				w_strb <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Write response.
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid_out <= 1'b1;
			// The count register is read only; unknown slots error out.
			s_axi_bresp_out  <= (aw_addr <= ADDR_EVENT_TYPE &&
				aw_addr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers.
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			global_enable      <= 1'b0;
			counter_enable_bit <= '0;
			counter_select     <= 3'd0;
			for (int i = 0; i < NUM_CNT; i++) begin
				event_code_field[i] <= CODE_RESET;
			end
		end else if (do_write) begin
			case (aw_addr)
				ADDR_CONTROL: begin
					if (w_strb[0]) begin
						global_enable <= w_data[CTRL_ENABLE_BIT];
					end
				end
				ADDR_ENABLE_SET: begin
					counter_enable_bit <= counter_enable_bit |
						wr_bits[NUM_CNT-1:0];
				end
				ADDR_ENABLE_CLR: begin
					counter_enable_bit <= counter_enable_bit &
						~wr_bits[NUM_CNT-1:0];
				end
				ADDR_SELECT: begin
					if (w_strb[0]) begin
						counter_select <= w_data[2:0];
					end
				end
				ADDR_EVENT_TYPE: begin
					if (w_strb[0]) begin
						event_code_field[counter_select] <= w_data[7:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Event counters, one per slot.
	// ----------------------------------------------------------------
	// Only the write strobe feeds the counters; the read strobe is
	// deliberately unused so a read can never be mistaken for a write.
	for (genvar g = 0; g < NUM_CNT; g++) begin : gen_cnt
		always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				count[g] <= '0;
			end else if (global_enable && counter_enable_bit[g] &&
					event_code_field[g] == CODE_CID_WRITE &&
					cid_access_in.write_exec) begin
				count[g] <= count[g] + 1'b1;
			end
		end

		// Every slot is checked, so whichever slot software enables
		// exercises the counting rules, not just a fixed one.
		a_count_on_write: assert property (
			@(posedge ref_clk_in) disable iff (!rst_n_in)
			(global_enable && counter_enable_bit[g] && !do_write &&
			 event_code_field[g] == CODE_CID_WRITE &&
			 cid_access_in.write_exec)
			|=> count[g] == $past(count[g]) + 1'b1)
			else $error("Enabled counter missed a write event.");
		a_read_no_count: assert property (
			@(posedge ref_clk_in) disable iff (!rst_n_in)
			!cid_access_in.write_exec |=> $stable(count[g]))
			else $error("Counter moved without a write event.");
		a_disabled_holds: assert property (
			@(posedge ref_clk_in) disable iff (!rst_n_in)
			!counter_enable_bit[g] |=> $stable(count[g]))
			else $error("Disabled counter changed.");
		a_global_gate: assert property (
			@(posedge ref_clk_in) disable iff (!rst_n_in)
			!global_enable |=> $stable(count[g]))
			else $error("Counter moved while monitor disabled.");
	end

	// ----------------------------------------------------------------
	// Event output bus.
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			event_output_bus_out <= '0;
		end else begin
			event_output_bus_out <= '0;
			event_output_bus_out[CID_EVENT_BIT] <= cid_access_in.write_exec;
		end
	end

	// ----------------------------------------------------------------
	// Read channel.
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0000_0000;
			s_axi_rresp_out   <= RESP_OKAY;
		end else begin
			s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				s_axi_arready_out <= 1'b0;
				s_axi_rvalid_out  <= 1'b1;
				s_axi_rresp_out   <= RESP_OKAY;
				s_axi_rdata_out   <= 32'h0000_0000;
				case (s_axi_araddr_in)
					ADDR_CONTROL:    s_axi_rdata_out[0] <= global_enable;
					ADDR_ENABLE_SET,
					ADDR_ENABLE_RD:  s_axi_rdata_out[NUM_CNT-1:0] <=
						counter_enable_bit;
					ADDR_ENABLE_CLR: s_axi_rdata_out[NUM_CNT-1:0] <=
						counter_enable_bit;
					ADDR_SELECT:     s_axi_rdata_out[2:0] <= counter_select;
					ADDR_EVENT_TYPE: s_axi_rdata_out[7:0] <=
						event_code_field[counter_select];
					ADDR_COUNT:      s_axi_rdata_out[CNT_W-1:0] <=
						count[counter_select];
					default:         s_axi_rresp_out <= RESP_SLVERR;
				endcase
			end else if (s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	a_event_bit: assert property (
		cid_access_in.write_exec |=> event_output_bus_out[CID_EVENT_BIT])
		else $error("Event output bit missed write.");
	a_enable_sticky: assert property (
		counter_enable_bit[NUM_CNT-1] &&
		!(do_write && aw_addr == ADDR_ENABLE_CLR)
		|=> counter_enable_bit[NUM_CNT-1])
		else $error("Enable bit lost without clear.");
	a_select_map: assert property (
		do_write && aw_addr == ADDR_EVENT_TYPE && w_strb[0]
		|=> event_code_field[$past(counter_select)] == $past(w_data[7:0]))
		else $error("Event code not mapped to selected counter.");
	a_select_write: assert property (
		do_write && aw_addr == ADDR_SELECT && w_strb[0]
		|=> counter_select == $past(w_data[2:0]))
		else $error("Selection field not updated.");

	c_write_count: cover property (count[NUM_CNT-1] == 32'h0000_0003);
	c_bus_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
	c_bus_read: cover property (s_axi_rvalid_out && s_axi_rready_in);

endmodule

// ==== tb/cidwc_counter_tb.sv ====
`timescale 1ns/1ps
module cidwc_counter_tb;
	import cidwc_pkg::*;

	// ----------------------------------------------------------------
	// Bench signals and bookkeeping.
	// ----------------------------------------------------------------
	logic          clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic          awready, wready, bvalid, arready, rvalid;
	logic [7:0]    awaddr, araddr;
	logic [31:0]   wdata, rdata, got;
	logic [3:0]    wstrb;
	logic [1:0]    bresp, rresp, resp;
	logic [15:0]   evt;
	cidwc_access_s cid;
	int            err_total, samples_checked, cyc;
	localparam logic [15:0] EV = 16'h0001 << CID_EVENT_BIT; // Bit 12 only.

	cidwc_counter cidwc_counter_inst (
		.ref_clk_in(clk), .rst_n_in(rst_n), .cid_access_in(cid),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
		.s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .event_output_bus_out(evt));

	// The clock toggles every 50 ns, a full period of 100 ns.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Reporting and comparison.
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("errors %0d, checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] g, e, input string m);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: %s got %h", $time, m, g);
		end
	endtask
	task automatic chk_bus(input logic [15:0] g, e, input string m);
		chk_word({16'h0000, g}, {16'h0000, e}, m);
	endtask

	// A hang is cut short well beyond the few hundred cycles needed.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			$display("unexpected at %0t: bench timed out", $time);
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Register bus master; each task lets one edge pass at its end.
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		bit aw, w;
		aw = 0;
		w = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (!aw && awready === 1'b1) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic axi_rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		got = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d);
		chk_word({30'd0, resp}, {30'd0, RESP_OKAY}, "write response");
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		axi_rd(a);
		chk_word({30'd0, resp}, {30'd0, RESP_OKAY}, "read response");
		chk_word(got, e, "register value");
	endtask
	// One access strobe; the event bus is judged one cycle later.
	task automatic cid_pulse(input logic wr, rd, input logic [15:0] e);
		cid <= '{write_exec: wr, read_exec: rd};
		@(posedge clk);
		cid <= '0;
		@(posedge clk);
		chk_bus(evt, e, "event bus pulse");
		@(posedge clk);
		chk_bus(evt, 16'h0000, "event bus idle");
	endtask

	// ----------------------------------------------------------------
	// Scenarios; counter 7 is the boundary index.
	// ----------------------------------------------------------------
	task automatic t_count_writes();
		rd_chk(ADDR_COUNT, 32'h0000_0000);
		rd_chk(ADDR_EVENT_TYPE, {24'h00_0000, CODE_RESET});
		wr_ok(ADDR_CONTROL, 32'h0000_0001);
		wr_ok(ADDR_ENABLE_SET, 32'h0000_0080);
		wr_ok(ADDR_SELECT, 32'h0000_0007);
		wr_ok(ADDR_EVENT_TYPE, {24'h00_0000, CODE_CID_WRITE});
		repeat (3) cid_pulse(1'b1, 1'b0, EV);
		rd_chk(ADDR_COUNT, 32'h0000_0003);
		rd_chk(ADDR_ENABLE_RD, 32'h0000_0080);
	endtask
	task automatic t_reads_and_global();
		repeat (2) cid_pulse(1'b0, 1'b1, 16'h0000);
		rd_chk(ADDR_COUNT, 32'h0000_0003);
		wr_ok(ADDR_CONTROL, 32'h0000_0000);
		cid_pulse(1'b1, 1'b0, EV);
		rd_chk(ADDR_COUNT, 32'h0000_0003);
		wr_ok(ADDR_CONTROL, 32'h0000_0001);
	endtask
	// Counter 0 gets the code but no enable; counter 7 keeps its type.
	task automatic t_select_split();
		wr_ok(ADDR_SELECT, 32'h0000_0000);
		wr_ok(ADDR_EVENT_TYPE, {24'h00_0000, CODE_CID_WRITE});
		cid_pulse(1'b1, 1'b0, EV);
		rd_chk(ADDR_COUNT, 32'h0000_0000);
		wr_ok(ADDR_SELECT, 32'h0000_0007);
		rd_chk(ADDR_EVENT_TYPE, {24'h00_0000, CODE_CID_WRITE});
		rd_chk(ADDR_COUNT, 32'h0000_0004);
	endtask
	// A read-only or unmapped place refuses and nothing changes.
	task automatic t_refusals();
		axi_wr(ADDR_COUNT, 32'h0000_0055);
		chk_word({30'd0, resp}, {30'd0, RESP_SLVERR}, "ro write");
		axi_wr(8'h1C, 32'h0000_0001);
		chk_word({30'd0, resp}, {30'd0, RESP_SLVERR}, "hole write");
		axi_rd(8'h1C);
		chk_word({30'd0, resp}, {30'd0, RESP_SLVERR}, "hole read");
		rd_chk(ADDR_COUNT, 32'h0000_0004);
	endtask
	// Readback of control and select, the clear path, and a write whose
	// enable byte is not strobed, which must leave the enables alone.
	task automatic t_enable_clear();
		rd_chk(ADDR_CONTROL, 32'h0000_0001);
		rd_chk(ADDR_SELECT, 32'h0000_0007);
		wr_ok(ADDR_ENABLE_CLR, 32'h0000_0080);
		rd_chk(ADDR_ENABLE_CLR, 32'h0000_0000);
		cid_pulse(1'b1, 1'b0, EV);
		rd_chk(ADDR_COUNT, 32'h0000_0004);
		wstrb <= 4'hE;
		wr_ok(ADDR_ENABLE_SET, 32'h0000_0080);
		wstrb <= 4'hF;
		rd_chk(ADDR_ENABLE_RD, 32'h0000_0000);
		wr_ok(ADDR_ENABLE_SET, 32'h0000_0080);
		cid_pulse(1'b1, 1'b0, EV);
		rd_chk(ADDR_COUNT, 32'h0000_0005);
		rd_chk(ADDR_ENABLE_SET, 32'h0000_0080);
	endtask

	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, cid, cyc} = '0;
		{err_total, samples_checked} = '0;
		wstrb = 4'hF;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_count_writes();
		t_reads_and_global();
		t_select_split();
		t_refusals();
		t_enable_clear();
		tally_and_finish();
	end
endmodule
